// File: design/cbt_exec_core.sv
// Operation
// [RULE_01] transfer-clear branch: pc+k+1 if T is zero, 1 or 2 cycles, flags untouched
// [RULE_02] overflow branches jump when V is one or zero; 1 or 2 cycles
// [RULE_03] interrupt branches jump when I is one or zero; 1 or 2 cycles
// [RULE_04] post-increment load reads at pointer, then pointer plus one, 2 cycles
// [RULE_05] pre-decrement load decrements pointer first, then reads new address, 2 cycles
// [RULE_06] displacement load reads pointer plus displacement, pointer unchanged, 2 cycles
// [RULE_07] direct load copies byte at absolute address into register, 2 cycles
// [RULE_08] post-increment store writes at pointer, then pointer plus one, 2 cycles
// [RULE_09] pre-decrement store decrements pointer first, then writes, 2 cycles
// [RULE_10] displacement store writes at pointer plus displacement, pointer unchanged
// [RULE_11] direct store writes register to absolute address, 2 cycles
// [RULE_12] program memory read via third pointer, optional increment, 3 cycles
// [RULE_13] push and pop move one byte to or from stack, 2 cycles each
// [RULE_14] io bit set and clear force one io register bit, 2 cycles
// [RULE_15] shifts and rotates take 1 cycle and update Z, C, N, V
// [RULE_16] bit store copies register bit to T; bit load copies T back
// [RULE_17] single flag set or clear forces only its named flag, 1 cycle
// [RULE_18] pointers are adjacent register pairs, stepped as full 16-bit values
// [RULE_19] program memory write stalls until the programming unit reports done
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module cbt_exec_core #(
  parameter logic [15:0] P_SP_RESET = cbt_pkg::CBT_SP_RESET
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_instr_valid,
  input wire cbt_pkg::cbt_op_t i_op,
  input wire cbt_pkg::cbt_mode_t i_mode,
  input wire logic [4:0] i_rd,
  input wire logic [1:0] i_ptr,
  input wire logic [5:0] i_disp,
  input wire logic [2:0] i_bit,
  input wire logic [15:0] i_k,
  input wire logic [5:0] i_io_sel,
  output logic o_ready,
  output logic [15:0] o_pc,
  output logic [15:0] o_dmem_addr,
  output logic o_dmem_rd,
  output logic o_dmem_wr,
  output logic [7:0] o_dmem_wdata,
  input wire logic [7:0] i_dmem_rdata,
  output logic [5:0] o_io_addr,
  output logic o_io_rd,
  output logic o_io_wr,
  output logic [7:0] o_io_wdata,
  input wire logic [7:0] i_io_rdata,
  output logic [15:0] o_pmem_addr,
  output logic o_pmem_rd,
  input wire logic [7:0] i_pmem_rdata,
  output logic o_spm_start,
  output logic [15:0] o_spm_word,
  input wire logic i_spm_done,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata
);
  import cbt_pkg::*;

  logic [7:0] regs_ff [CBT_REG_COUNT];
  logic [7:0] nxt_regs [CBT_REG_COUNT];
  logic [7:0] status_ff, nxt_status;
  logic [15:0] pc_ff, nxt_pc, sp_ff, nxt_sp;
  cbt_state_t state_ff, nxt_state;
  logic ready_ff, nxt_ready;
  logic [15:0] dmem_addr_ff, nxt_dmem_addr;
  logic dmem_rd_ff, nxt_dmem_rd, dmem_wr_ff, nxt_dmem_wr;
  logic [7:0] dmem_wdata_ff, nxt_dmem_wdata;
  logic [5:0] io_addr_ff, nxt_io_addr;
  logic io_rd_ff, nxt_io_rd, io_wr_ff, nxt_io_wr, io_set_ff, nxt_io_set;
  logic [7:0] io_wdata_ff, nxt_io_wdata;
  logic [2:0] io_bit_ff, nxt_io_bit;
  logic [15:0] pmem_addr_ff, nxt_pmem_addr, spm_word_ff, nxt_spm_word;
  logic pmem_rd_ff, nxt_pmem_rd, spm_start_ff, nxt_spm_start;
  logic [4:0] dst_ff, nxt_dst;
  logic [7:0] reg_rdata_ff, nxt_reg_rdata;

  logic take, branch_hit, is_disp, ptr_step;
  logic [4:0] ptr_lo_idx, ptr_hi_idx;
  logic [15:0] ptr_val, ptr_delta, ptr_sum, eff_addr, pc_target, pc_plus1, pc_plus2;
  logic [7:0] src_val, io_mask;
  logic [7:0] sh_res;
  logic sh_c, sh_z, sh_n, sh_v;

  // a request is taken only while idle and ready
  assign take = i_instr_valid && ready_ff && (state_ff == s_exec);
  assign src_val = regs_ff[i_rd];

  // pointer pair from two adjacent registers; program memory always takes the third pair
  assign ptr_lo_idx = CBT_PTR_BASE + {2'b00, ((i_op inside {program_memory_read,
                      program_memory_write}) ? 2'h2 : i_ptr), 1'b0}; // [RULE_12] [RULE_18]
  assign ptr_hi_idx = ptr_lo_idx | 5'h01;
  assign ptr_val = {regs_ff[ptr_hi_idx], regs_ff[ptr_lo_idx]}; // [RULE_18]
  assign is_disp = (i_op == displacement_load) || (i_op == displacement_store);
  assign ptr_step = ((i_op == indirect_load) || (i_op == indirect_store)) &&
                    ((i_mode == mode_postinc) || (i_mode == mode_predec));
  // pre-decrement and displacement address through the adder, others use the pointer
  assign eff_addr = (is_disp || (i_mode == mode_predec)) ? ptr_sum : ptr_val; // [RULE_05] [RULE_06]
  assign pc_plus1 = 16'(pc_ff + 16'h0001);
  assign pc_plus2 = 16'(pc_ff + 16'h0002);
  assign io_mask = 8'(8'h01 << io_bit_ff);

  // step applied to the selected pointer
  always_comb begin
    ptr_delta = 16'h0000;
    if (is_disp) begin
      ptr_delta = {10'h000, i_disp}; // [RULE_06] [RULE_10]
    end else if (i_mode == mode_postinc) begin
      ptr_delta = CBT_STEP_INC;
    end else if (i_mode == mode_predec) begin
      ptr_delta = CBT_STEP_DEC;
    end
  end

  cbt_adder #(.WIDTH(16)) u_ptr_add (
    .i_a(ptr_val),
    .i_b(ptr_delta),
    .i_cin(1'b0),
    .o_sum(ptr_sum)
  );

  // branch target is pc plus offset plus one
  cbt_adder #(.WIDTH(16)) u_pc_add (
    .i_a(pc_ff),
    .i_b(i_k),
    .i_cin(1'b1),
    .o_sum(pc_target)
  );

  cbt_shift_unit u_shift (
    .i_op(i_op),
    .i_val(src_val),
    .i_carry(status_ff[CBT_FLAG_C]),
    .o_res(sh_res),
    .o_carry(sh_c),
    .o_zero(sh_z),
    .o_neg(sh_n),
    .o_ovf(sh_v)
  );

  // branch conditions on single flags
  always_comb begin
    case (i_op)
      branch_transfer_clear: branch_hit = !status_ff[CBT_FLAG_T]; // [RULE_01]
      branch_overflow_set: branch_hit = status_ff[CBT_FLAG_V]; // [RULE_02]
      branch_overflow_clear: branch_hit = !status_ff[CBT_FLAG_V]; // [RULE_02]
      branch_irq_enabled: branch_hit = status_ff[CBT_FLAG_I]; // [RULE_03]
      branch_irq_disabled: branch_hit = !status_ff[CBT_FLAG_I]; // [RULE_03]
      default: branch_hit = 1'b0;
    endcase
  end

  // core next state; strobes default low so each lasts one cycle
  always_comb begin
    nxt_regs = regs_ff;
    nxt_status = status_ff;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    nxt_state = state_ff;
    nxt_ready = ready_ff;
    nxt_dmem_addr = dmem_addr_ff;
    nxt_dmem_rd = 1'b0;
    nxt_dmem_wr = 1'b0;
    nxt_dmem_wdata = dmem_wdata_ff;
    nxt_io_addr = io_addr_ff;
    nxt_io_rd = 1'b0;
    nxt_io_wr = 1'b0;
    nxt_io_wdata = io_wdata_ff;
    nxt_io_bit = io_bit_ff;
    nxt_io_set = io_set_ff;
    nxt_pmem_addr = pmem_addr_ff;
    nxt_pmem_rd = 1'b0;
    nxt_spm_start = 1'b0;
    nxt_spm_word = spm_word_ff;
    nxt_dst = dst_ff;
    // software first, so an instruction in the same cycle has the last word
    if (i_reg_wr) begin
      case (i_reg_addr)
        CBT_OFS_STATUS: nxt_status = i_reg_wdata;
        CBT_OFS_SP_LO: nxt_sp[7:0] = i_reg_wdata;
        CBT_OFS_SP_HI: nxt_sp[15:8] = i_reg_wdata;
        default: ;
      endcase
    end
    unique case (state_ff)
      s_exec: begin
        if (take) begin
          nxt_pc = ((i_op == direct_load) || (i_op == direct_store)) ? pc_plus2 : pc_plus1;
          nxt_dst = i_rd;
          if (ptr_step) begin
            {nxt_regs[ptr_hi_idx], nxt_regs[ptr_lo_idx]} = ptr_sum; // [RULE_04] [RULE_08] [RULE_18]
          end
          case (i_op)
            branch_transfer_clear, branch_overflow_set, branch_overflow_clear,
            branch_irq_enabled, branch_irq_disabled: begin
              // a taken branch costs one extra cycle to refetch
              if (branch_hit) begin
                nxt_pc = pc_target; // [RULE_01] [RULE_02] [RULE_03]
                nxt_ready = 1'b0;
                nxt_state = s_flush;
              end
            end
            indirect_load, displacement_load: begin
              nxt_dmem_addr = eff_addr; // [RULE_04] [RULE_05] [RULE_06]
              nxt_dmem_rd = 1'b1;
              nxt_ready = 1'b0;
              nxt_state = s_load;
            end
            direct_load: begin
              nxt_dmem_addr = i_k; // [RULE_07]
              nxt_dmem_rd = 1'b1;
              nxt_ready = 1'b0;
              nxt_state = s_load;
            end
            indirect_store, displacement_store, direct_store: begin
              nxt_dmem_addr = (i_op == direct_store) ? i_k : eff_addr; // [RULE_08] [RULE_09] [RULE_10] [RULE_11]
              nxt_dmem_wdata = src_val;
              nxt_dmem_wr = 1'b1;
              nxt_ready = 1'b0;
              nxt_state = s_flush;
            end
            stack_push: begin
              nxt_dmem_addr = sp_ff; // [RULE_13]
              nxt_dmem_wdata = src_val;
              nxt_dmem_wr = 1'b1;
              nxt_sp = 16'(sp_ff - 16'h0001);
              nxt_ready = 1'b0;
              nxt_state = s_flush;
            end
            stack_pop: begin
              nxt_dmem_addr = 16'(sp_ff + 16'h0001); // [RULE_13]
              nxt_sp = 16'(sp_ff + 16'h0001);
              nxt_dmem_rd = 1'b1;
              nxt_ready = 1'b0;
              nxt_state = s_load;
            end
            program_memory_read: begin
              nxt_pmem_addr = ptr_val; // [RULE_12]
              nxt_pmem_rd = 1'b1;
              if (i_mode == mode_postinc) begin
                {nxt_regs[ptr_hi_idx], nxt_regs[ptr_lo_idx]} = ptr_sum; // [RULE_12]
              end
              nxt_ready = 1'b0;
              nxt_state = s_pmem;
            end
            program_memory_write: begin
              nxt_pmem_addr = ptr_val;
              nxt_spm_word = {regs_ff[CBT_R1], regs_ff[CBT_R0]};
              nxt_spm_start = 1'b1;
              nxt_ready = 1'b0;
              nxt_state = s_spm;
            end
            io_bit_set, io_bit_clear: begin
              // read-modify-write; the rest of the register keeps its value
              nxt_io_addr = i_io_sel; // [RULE_14]
              nxt_io_bit = i_bit;
              nxt_io_set = (i_op == io_bit_set);
              nxt_io_rd = 1'b1;
              nxt_ready = 1'b0;
              nxt_state = s_io;
            end
            shift_left_logical, shift_right_logical, rotate_left_carry,
            rotate_right_carry, shift_right_arith: begin
              nxt_regs[i_rd] = sh_res; // [RULE_15]
              nxt_status[CBT_FLAG_C] = sh_c;
              nxt_status[CBT_FLAG_Z] = sh_z;
              nxt_status[CBT_FLAG_N] = sh_n;
              nxt_status[CBT_FLAG_V] = sh_v;
            end
            bit_to_transfer_flag: nxt_status[CBT_FLAG_T] = src_val[i_bit]; // [RULE_16]
            transfer_flag_to_bit: nxt_regs[i_rd][i_bit] = status_ff[CBT_FLAG_T]; // [RULE_16]
            indexed_flag_set: nxt_status[i_bit] = 1'b1; // [RULE_17]
            indexed_flag_clear: nxt_status[i_bit] = 1'b0; // [RULE_17]
            carry_set_op: nxt_status[CBT_FLAG_C] = 1'b1; // [RULE_17]
            carry_clear_op: nxt_status[CBT_FLAG_C] = 1'b0; // [RULE_17]
            negative_set_op: nxt_status[CBT_FLAG_N] = 1'b1; // [RULE_17]
            negative_clear_op: nxt_status[CBT_FLAG_N] = 1'b0; // [RULE_17]
            zero_set_op: nxt_status[CBT_FLAG_Z] = 1'b1; // [RULE_17]
            zero_clear_op: nxt_status[CBT_FLAG_Z] = 1'b0; // [RULE_17]
            irq_enable_op: nxt_status[CBT_FLAG_I] = 1'b1; // [RULE_17]
            irq_disable_op: nxt_status[CBT_FLAG_I] = 1'b0; // [RULE_17]
            signed_set_op: nxt_status[CBT_FLAG_S] = 1'b1; // [RULE_17]
            default: ;
          endcase
        end
      end
      // data memory answers in the cycle of the read strobe
      s_load: begin
        nxt_regs[dst_ff] = i_dmem_rdata; // [RULE_04] [RULE_07] [RULE_13]
        nxt_ready = 1'b1;
        nxt_state = s_exec;
      end
      // program memory answers one cycle after its strobe
      s_pmem: nxt_state = s_pmem_data;
      s_pmem_data: begin
        nxt_regs[dst_ff] = i_pmem_rdata; // [RULE_12]
        nxt_ready = 1'b1;
        nxt_state = s_exec;
      end
      s_io: begin
        nxt_io_wdata = io_set_ff ? (i_io_rdata | io_mask) : (i_io_rdata & ~io_mask); // [RULE_14]
        nxt_io_wr = 1'b1;
        nxt_ready = 1'b1;
        nxt_state = s_exec;
      end
      s_flush: begin
        nxt_ready = 1'b1;
        nxt_state = s_exec;
      end
      // no fixed length: wait as long as the programming unit needs
      s_spm: begin
        if (i_spm_done) begin
          nxt_ready = 1'b1; // [RULE_19]
          nxt_state = s_exec;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      regs_ff <= '{default: 8'h00};
      status_ff <= CBT_STATUS_RESET;
      pc_ff <= CBT_PC_RESET;
      sp_ff <= P_SP_RESET;
      state_ff <= s_exec;
      ready_ff <= 1'b1;
      dmem_addr_ff <= 16'h0000;
      dmem_rd_ff <= 1'b0;
      dmem_wr_ff <= 1'b0;
      dmem_wdata_ff <= 8'h00;
      io_addr_ff <= 6'h00;
      io_rd_ff <= 1'b0;
      io_wr_ff <= 1'b0;
      io_wdata_ff <= 8'h00;
      io_bit_ff <= 3'h0;
      io_set_ff <= 1'b0;
      pmem_addr_ff <= 16'h0000;
      pmem_rd_ff <= 1'b0;
      spm_start_ff <= 1'b0;
      spm_word_ff <= 16'h0000;
      dst_ff <= 5'h00;
    end else begin
      regs_ff <= nxt_regs;
      status_ff <= nxt_status;
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      dmem_addr_ff <= nxt_dmem_addr;
      dmem_rd_ff <= nxt_dmem_rd;
      dmem_wr_ff <= nxt_dmem_wr;
      dmem_wdata_ff <= nxt_dmem_wdata;
      io_addr_ff <= nxt_io_addr;
      io_rd_ff <= nxt_io_rd;
      io_wr_ff <= nxt_io_wr;
      io_wdata_ff <= nxt_io_wdata;
      io_bit_ff <= nxt_io_bit;
      io_set_ff <= nxt_io_set;
      pmem_addr_ff <= nxt_pmem_addr;
      pmem_rd_ff <= nxt_pmem_rd;
      spm_start_ff <= nxt_spm_start;
      spm_word_ff <= nxt_spm_word;
      dst_ff <= nxt_dst;
    end
  end

  // software read data, valid only in the cycle after the strobe
  always_comb begin
    nxt_reg_rdata = 8'h00;
    if (i_reg_rd) begin
      case (i_reg_addr)
        CBT_OFS_STATUS: nxt_reg_rdata = status_ff;
        CBT_OFS_SP_LO: nxt_reg_rdata = sp_ff[7:0];
        CBT_OFS_SP_HI: nxt_reg_rdata = sp_ff[15:8];
        CBT_OFS_PC_LO: nxt_reg_rdata = pc_ff[7:0];
        CBT_OFS_PC_HI: nxt_reg_rdata = pc_ff[15:8];
        default: nxt_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

  assign o_ready = ready_ff;
  assign o_pc = pc_ff;
  assign o_dmem_addr = dmem_addr_ff;
  assign o_dmem_rd = dmem_rd_ff;
  assign o_dmem_wr = dmem_wr_ff;
  assign o_dmem_wdata = dmem_wdata_ff;
  assign o_io_addr = io_addr_ff;
  assign o_io_rd = io_rd_ff;
  assign o_io_wr = io_wr_ff;
  assign o_io_wdata = io_wdata_ff;
  assign o_pmem_addr = pmem_addr_ff;
  assign o_pmem_rd = pmem_rd_ff;
  assign o_spm_start = spm_start_ff;
  assign o_spm_word = spm_word_ff;
  assign o_reg_rdata = reg_rdata_ff;

  default clocking cb_chk @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  chk_transfer_branch: // [RULE_01]
  assert property (take && i_op == branch_transfer_clear && !status_ff[CBT_FLAG_T]
                   |=> (o_pc == $past(pc_target) && !o_ready) ##1 o_ready)
    else $error("transfer-clear branch target or length wrong");
  chk_ovf_branch: // [RULE_02]
  assert property (take && ((i_op == branch_overflow_set && status_ff[CBT_FLAG_V]) ||
                   (i_op == branch_overflow_clear && !status_ff[CBT_FLAG_V]))
                   |=> o_pc == $past(pc_target) && $stable(status_ff))
    else $error("overflow branch missed or touched flags");
  chk_irq_branch_skip: // [RULE_03]
  assert property (take && i_op == branch_irq_enabled && !status_ff[CBT_FLAG_I]
                   |=> o_pc == $past(pc_plus1) && o_ready)
    else $error("untaken interrupt branch did not fall through in one cycle");
  chk_load_timing: // [RULE_04]
  assert property (take && i_op == indirect_load |=> (o_dmem_rd && !o_ready) ##1 o_ready)
    else $error("indirect load not two cycles");
  chk_predec_addr: // [RULE_05]
  assert property (take && i_op == indirect_load && i_mode == mode_predec
                   |=> o_dmem_addr == $past(ptr_sum))
    else $error("pre-decrement load used the old pointer");
  chk_store_data: // [RULE_08]
  assert property (take && i_op == indirect_store |=> o_dmem_wr && o_dmem_wdata == $past(src_val))
    else $error("indirect store data wrong");
  chk_pmem_length: // [RULE_12]
  assert property (take && i_op == program_memory_read |=> !o_ready [*2] ##1 o_ready)
    else $error("program memory read not three cycles");
  chk_push_addr: // [RULE_13]
  assert property (take && i_op == stack_push
                   |=> o_dmem_wr && o_dmem_addr == $past(sp_ff) && sp_ff == 16'(o_dmem_addr - 16'h0001))
    else $error("push address or stack step wrong");
  chk_io_bit_write: // [RULE_14]
  assert property (o_io_wr |-> o_io_wdata[io_bit_ff] == io_set_ff && $past(io_rd_ff))
    else $error("io bit write wrong or not after read");
  chk_spm_stall: // [RULE_19]
  assert property (state_ff == s_spm && !i_spm_done |=> !o_ready)
    else $error("core resumed before programming finished");

endmodule
`default_nettype wire

// File: design/cbt_pkg.sv
package cbt_pkg;

  localparam int CBT_REG_COUNT = 32;

  // register indices used by fixed operand forms
  localparam logic [4:0] CBT_R0 = 5'h00;
  localparam logic [4:0] CBT_R1 = 5'h01;
  // low half of the first pointer pair; the pairs follow in steps of two
  localparam logic [4:0] CBT_PTR_BASE = 5'h1a;

  // bit positions inside the status flags register
  localparam int CBT_FLAG_C = 0;
  localparam int CBT_FLAG_Z = 1;
  localparam int CBT_FLAG_N = 2;
  localparam int CBT_FLAG_V = 3;
  localparam int CBT_FLAG_S = 4;
  localparam int CBT_FLAG_H = 5;
  localparam int CBT_FLAG_T = 6;
  localparam int CBT_FLAG_I = 7;

  // software register port offsets
  localparam logic [2:0] CBT_OFS_STATUS = 3'h0;
  localparam logic [2:0] CBT_OFS_SP_LO = 3'h1;
  localparam logic [2:0] CBT_OFS_SP_HI = 3'h2;
  localparam logic [2:0] CBT_OFS_PC_LO = 3'h3;
  localparam logic [2:0] CBT_OFS_PC_HI = 3'h4;

  // reset values
  localparam logic [7:0] CBT_STATUS_RESET = 8'h00;
  localparam logic [15:0] CBT_PC_RESET = 16'h0000;
  localparam logic [15:0] CBT_SP_RESET = 16'h00ff;

  // pointer steps
  localparam logic [15:0] CBT_STEP_INC = 16'h0001;
  localparam logic [15:0] CBT_STEP_DEC = 16'hffff;

  typedef enum logic [5:0] {
    no_operation,
    branch_transfer_clear, branch_overflow_set, branch_overflow_clear,
    branch_irq_enabled, branch_irq_disabled,
    indirect_load, displacement_load, direct_load,
    indirect_store, displacement_store, direct_store,
    program_memory_read, program_memory_write, stack_push, stack_pop,
    io_bit_set, io_bit_clear,
    shift_left_logical, shift_right_logical, rotate_left_carry, rotate_right_carry,
    shift_right_arith, bit_to_transfer_flag, transfer_flag_to_bit,
    indexed_flag_set, indexed_flag_clear,
    carry_set_op, carry_clear_op, negative_set_op, negative_clear_op,
    zero_set_op, zero_clear_op, irq_enable_op, irq_disable_op, signed_set_op
  } cbt_op_t;

  typedef enum logic [1:0] {mode_plain, mode_postinc, mode_predec, mode_disp} cbt_mode_t;

  typedef enum logic [2:0] {s_exec, s_load, s_pmem, s_pmem_data, s_io, s_flush, s_spm} cbt_state_t;

endpackage

// File: design/cbt_adder.sv
`timescale 1ns/10ps
`default_nettype none
// pointer stepping and branch targets share this adder shape
module cbt_adder #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] i_a,
  input wire logic [WIDTH-1:0] i_b,
  input wire logic i_cin,
  output logic [WIDTH-1:0] o_sum
);
  // wraps modulo the width, as pointers and the counter do
  assign o_sum = WIDTH'(i_a + i_b + {{(WIDTH-1){1'b0}}, i_cin});
endmodule
`default_nettype wire

// File: design/cbt_shift_unit.sv
`timescale 1ns/10ps
`default_nettype none
module cbt_shift_unit (
  input wire cbt_pkg::cbt_op_t i_op,
  input wire logic [7:0] i_val,
  input wire logic i_carry,
  output logic [7:0] o_res,
  output logic o_carry,
  output logic o_zero,
  output logic o_neg,
  output logic o_ovf
);
  import cbt_pkg::*;

  // result and carry per shift kind, then the common flags
  always_comb begin
    o_res = i_val;
    o_carry = i_carry;
    case (i_op)
      shift_left_logical: begin
        o_res = {i_val[6:0], 1'b0}; // [RULE_15]
        o_carry = i_val[7];
      end
      shift_right_logical: begin
        o_res = {1'b0, i_val[7:1]}; // [RULE_15]
        o_carry = i_val[0];
      end
      rotate_left_carry: begin
        o_res = {i_val[6:0], i_carry}; // [RULE_15]
        o_carry = i_val[7];
      end
      rotate_right_carry: begin
        o_res = {i_carry, i_val[7:1]}; // [RULE_15]
        o_carry = i_val[0];
      end
      shift_right_arith: begin
        o_res = {i_val[7], i_val[7:1]}; // [RULE_15]
        o_carry = i_val[0];
      end
      default: begin
        o_res = i_val;
        o_carry = i_carry;
      end
    endcase
    o_neg = o_res[7];
    o_zero = (o_res == 8'h00);
    // overflow of a shift is negative xor carry
    o_ovf = o_res[7] ^ o_carry;
  end
endmodule
`default_nettype wire

// File: test/cbt_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// data space and io space behind the core; an idle read bus shows a toggling pattern
module cbt_mem_model (
  input wire logic i_clk_sys,
  input wire logic [15:0] i_daddr,
  input wire logic i_drd,
  input wire logic i_dwr,
  input wire logic [7:0] i_dwdata,
  output logic [7:0] o_drdata,
  input wire logic [5:0] i_iaddr,
  input wire logic i_ird,
  input wire logic i_iwr,
  input wire logic [7:0] i_iwdata,
  output logic [7:0] o_irdata,
  input wire logic [15:0] i_paddr,
  input wire logic i_prd,
  output logic [7:0] o_prdata,
  input wire logic i_spm_start,
  input wire logic [15:0] i_spm_word,
  output logic o_spm_done
);
  logic [7:0] dmem [0:65535];
  logic [7:0] io [0:63];
  logic [7:0] tog = 8'h5a;
  logic prd_q = 1'b0;
  logic [2:0] spm_q = 3'h0;
  logic [15:0] pword;
  // data only within the strobe cycle, never a stale byte
  assign o_drdata = i_drd ? dmem[i_daddr] : tog;
  assign o_irdata = i_ird ? io[i_iaddr] : tog;
  // program bytes follow the address, a cycle after the strobe
  assign o_prdata = prd_q ? (i_paddr[7:0] ^ 8'h3c) : tog;
  // programming ends three cycles after its start pulse
  assign o_spm_done = spm_q[2];
  // writes land at the edge that ends the strobe
  always @(posedge i_clk_sys) begin
    tog <= ~tog;
    prd_q <= i_prd;
    spm_q <= {spm_q[1:0], i_spm_start};
    if (i_spm_start) pword <= i_spm_word;
    if (i_dwr) dmem[i_daddr] <= i_dwdata;
    if (i_iwr) io[i_iaddr] <= i_iwdata;
  end
endmodule
`default_nettype wire

// File: test/tb_cbt_exec_core.sv
`timescale 1ns/10ps
`default_nettype none
module tb_cbt_exec_core;
  import cbt_pkg::*;
  logic clk, rst_n, vld, rwr, rrd, ready, drd, dwr, ird, iwr, prd, spms, sdone;
  cbt_op_t op;
  cbt_mode_t mode;
  logic [4:0] rd;
  logic [1:0] ptr;
  logic [2:0] bt, raddr;
  logic [15:0] k, pc, daddr, paddr, sword;
  logic [5:0] iaddr, dsp;
  logic [7:0] dwd, drdat, iwd, irdat, rwdata, rdata, prdat;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  cbt_exec_core u_cbt_exec_core (.i_clk_sys(clk), .i_rst_n(rst_n), .i_instr_valid(vld),
    .i_op(op), .i_mode(mode), .i_rd(rd), .i_ptr(ptr), .i_disp(dsp), .i_bit(bt), .i_k(k),
    .i_io_sel(6'h05), .o_ready(ready), .o_pc(pc), .o_dmem_addr(daddr), .o_dmem_rd(drd),
    .o_dmem_wr(dwr), .o_dmem_wdata(dwd), .i_dmem_rdata(drdat), .o_io_addr(iaddr),
    .o_io_rd(ird), .o_io_wr(iwr), .o_io_wdata(iwd), .i_io_rdata(irdat), .o_pmem_addr(paddr),
    .o_pmem_rd(prd), .i_pmem_rdata(prdat), .o_spm_start(spms), .o_spm_word(sword),
    .i_spm_done(sdone),
    .i_reg_addr(raddr), .i_reg_wdata(rwdata), .i_reg_wr(rwr), .i_reg_rd(rrd),
    .o_reg_rdata(rdata));
  cbt_mem_model u_cbt_mem_model (.i_clk_sys(clk), .i_daddr(daddr), .i_drd(drd), .i_dwr(dwr),
    .i_dwdata(dwd), .o_drdata(drdat), .i_iaddr(iaddr), .i_ird(ird), .i_iwr(iwr),
    .i_iwdata(iwd), .o_irdata(irdat), .i_paddr(paddr), .i_prd(prd), .o_prdata(prdat),
    .i_spm_start(spms), .i_spm_word(sword), .o_spm_done(sdone));
  // 40 mhz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // hold until taken, then wait for ready
  task automatic ex(input cbt_op_t o, input logic [4:0] r = 5'h00, input logic [15:0] kk = 16'h0,
    input logic [2:0] b = 3'h0, input cbt_mode_t m = mode_plain, input logic [1:0] p = 2'h0);
    op <= o;
    rd <= r;
    k <= kk;
    bt <= b;
    mode <= m;
    ptr <= p;
    vld <= 1'b1;
    do @(posedge clk); while (ready !== 1'b1);
    vld <= 1'b0;
    do @(posedge clk); while (ready !== 1'b1);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    raddr <= a;
    rwdata <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rr(input logic [2:0] a, input logic [7:0] e);
    raddr <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    @(posedge clk);
    chk(rdata, e);
  endtask
  // hang guard, tests need well under a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    {rst_n, vld, rwr, rrd, rd, ptr, bt, raddr, k, rwdata, dsp} <= '0;
    op <= no_operation;
    mode <= mode_plain;
    u_cbt_mem_model.dmem[16'h0010] = 8'h81;
    u_cbt_mem_model.io[5] = 8'h41;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rr(CBT_OFS_STATUS, 8'h00);
    wr(CBT_OFS_STATUS, 8'h20);
    rr(CBT_OFS_STATUS, 8'h20);
    rr(3'h7, 8'h00);
    ex(indexed_flag_clear, 5'h00, 16'h0, 3'h5);
    rr(CBT_OFS_STATUS, 8'h00);
    $display("test regs done");
    ex(direct_load, 5'h10, 16'h0010);
    chk(pc, 16'h0003);
    ex(shift_left_logical, 5'h10);
    rr(CBT_OFS_STATUS, 8'h09);
    ex(direct_store, 5'h10, 16'h0020);
    chk(u_cbt_mem_model.dmem[16'h0020], 8'h02);
    ex(branch_overflow_clear, 5'h00, 16'h0004);
    chk(pc, 16'h0007);
    ex(branch_overflow_set, 5'h00, 16'h0004);
    chk(pc, 16'h000c);
    ex(irq_enable_op);
    ex(branch_irq_disabled, 5'h00, 16'h0004);
    ex(branch_irq_enabled, 5'h00, 16'hfffe);
    chk(pc, 16'h000d);
    ex(branch_transfer_clear, 5'h00, 16'h0003);
    chk(pc, 16'h0011);
    ex(bit_to_transfer_flag, 5'h10, 16'h0, 3'h1);
    rr(CBT_OFS_STATUS, 8'hc9);
    ex(branch_transfer_clear, 5'h00, 16'h0003);
    chk(pc, 16'h0013);
    $display("test branches done");
    ex(indirect_store, 5'h10, 16'h0, 3'h0, mode_predec);
    chk(u_cbt_mem_model.dmem[16'hffff], 8'h02);
    ex(indirect_load, 5'h11, 16'h0, 3'h0, mode_postinc);
    ex(transfer_flag_to_bit, 5'h11, 16'h0, 3'h7);
    ex(indirect_store, 5'h11);
    chk(u_cbt_mem_model.dmem[16'h0000], 8'h82);
    ex(io_bit_set, 5'h00, 16'h0, 3'h3);
    rr(CBT_OFS_PC_LO, 8'h18);
    chk(u_cbt_mem_model.io[5], 8'h49);
    ex(program_memory_read, 5'h14, 16'h0, 3'h0, mode_postinc);
    ex(indirect_load, 5'h16, 16'h0, 3'h0, mode_predec, 2'h2);
    ex(stack_push, 5'h16);
    chk(u_cbt_mem_model.dmem[16'h00ff], 8'h82);
    ex(stack_pop, 5'h00);
    ex(program_memory_write);
    chk(u_cbt_mem_model.pword, 16'h0082);
    dsp <= 6'h05;
    ex(displacement_store, 5'h14, 16'h0, 3'h0, mode_plain, 2'h1);
    ex(displacement_load, 5'h15, 16'h0, 3'h0, mode_plain, 2'h1);
    ex(indirect_store, 5'h15, 16'h0, 3'h0, mode_plain, 2'h1);
    chk(u_cbt_mem_model.dmem[16'h0005], 8'h3c);
    chk(u_cbt_mem_model.dmem[16'h0000], 8'h3c);
    ex(irq_disable_op);
    ex(branch_irq_enabled, 5'h00, 16'h0040);
    chk(pc, 16'h0022);
    $display("test transfers done");
    report_and_stop;
  end
endmodule
`default_nettype wire
